// file: smt_timer.sv
`timescale 1ns/1ps
`include "smt_cfg.svh"

module smt_timer
  import smt_pkg::*;
#(
  parameter int FS_DIV = `SMT_FS_DIV,
  parameter int FILT_CYC = `SMT_FILT_CYC
) (
  // clock and reset
  input wire logic clock_in,
  input wire logic srst_in,
  // control
  input wire logic ctrl_wr_in,
  input wire smt_ctrl_s ctrl_in,
  input wire logic divider_tap_sel_in,
  input wire logic slow_mode_in,
  input wire logic stop_entry_in,
  // timer register writes
  input wire smt_wr_s reg_wr_in,
  // external pin
  input wire logic timer_input_pin_in,
  // status
  output logic [15:0] count_out,
  output logic [15:0] compare_period_reg_out,
  output logic [15:0] capture_second_reg_out,
  output smt_ctrl_s timer_control_reg_out,
  output logic running_out,
  output logic timer_match_irq_out
);

  smt_ctrl_s ctrl_q;
  smt_state_e state_q;
  smt_state_e state_d;
  logic [15:0] cnt_d;
  logic irq_d;
  logic [7:0] lo_q;
  logic [15:0] stage_q [2];
  logic pend_q [2];
  logic tick;
  logic pin_level;
  logic pin_rise;
  logic pin_fall;
  logic std_mode;
  logic win_mode;
  logic event_mode;
  logic timer_mode;
  logic trig_mode;
  logic active;
  logic trig_edge;
  logic opp_edge;
  logic win_active;
  logic src_clk;
  logic cnt_tick;
  logic match;
  logic ctrl_hold;

  // ---------------------------------------------------------------
  // source clock and pin
  // ---------------------------------------------------------------
  smt_prescaler #(
    .FS_DIV(FS_DIV)
  ) u_prescaler (
    .clock_in(clock_in),
    .srst_in(srst_in),
    .source_clk_sel_in(ctrl_q.source_clk_sel),
    .divider_tap_sel_in(divider_tap_sel_in),
    .slow_mode_in(slow_mode_in),
    .tick_out(tick)
  );

  smt_pin_filter #(
    .FILT_CYC(FILT_CYC)
  ) u_pin_filter (
    .clock_in(clock_in),
    .srst_in(srst_in),
    .timer_input_pin_in(timer_input_pin_in),
    .slow_mode_in(slow_mode_in),
    .level_out(pin_level),
    .rise_out(pin_rise),
    .fall_out(pin_fall)
  );

  // ---------------------------------------------------------------
  // mode decode
  // ---------------------------------------------------------------
  assign std_mode = (ctrl_q.op_mode_sel == `SMT_MODE_STD);
  assign win_mode = (ctrl_q.op_mode_sel == `SMT_MODE_WIN);
  assign event_mode = std_mode && ctrl_q.start_ctrl[1]
                      && (ctrl_q.source_clk_sel == `SMT_SRC_EXT);
  assign trig_mode = std_mode && ctrl_q.start_ctrl[1]
                     && (ctrl_q.source_clk_sel != `SMT_SRC_EXT);
  assign timer_mode = std_mode && (ctrl_q.start_ctrl == `SMT_START_CMD)
                      && (ctrl_q.source_clk_sel != `SMT_SRC_EXT);
  // modes 10 and 11 are not built and leave the counter idle
  assign active = timer_mode || event_mode || trig_mode
                  || (win_mode && ctrl_q.start_ctrl[1]);
  assign trig_edge = ctrl_q.start_ctrl[0] ? pin_fall : pin_rise;
  assign opp_edge = ctrl_q.start_ctrl[0] ? pin_rise : pin_fall;
  assign win_active = ctrl_q.start_ctrl[0] ? ~pin_level : pin_level;
  assign src_clk = event_mode ? trig_edge : tick;
  assign cnt_tick = win_mode ? (tick && win_active) : tick;
  assign match = (count_out == compare_period_reg_out);
  assign ctrl_hold = !ctrl_wr_in && !stop_entry_in;

  // ---------------------------------------------------------------
  // control register
  // ---------------------------------------------------------------
  always_ff @(posedge clock_in)
  begin
    if (srst_in)
      ctrl_q <= '0;
    else if (stop_entry_in)
      ctrl_q.start_ctrl <= `SMT_START_STOP;
    else if (ctrl_wr_in)
      ctrl_q <= ctrl_in;
  end

  // ---------------------------------------------------------------
  // counter sequencing
  // ---------------------------------------------------------------
  always_comb
  begin
    state_d = state_q;
    cnt_d = count_out;
    irq_d = 1'b0;
    if (!active)
    begin
      state_d = ST_IDLE;
      cnt_d = `SMT_CNT_RST;
    end
    else
      unique case (state_q)
        ST_IDLE:
        begin
          cnt_d = `SMT_CNT_RST;
          state_d = trig_mode ? ST_HALT : ST_RUN;
        end
        ST_RUN:
        begin
          if (event_mode)
          begin
            if (trig_edge)
              cnt_d = count_out + 16'h1;
            else if (opp_edge && match)
            begin
              cnt_d = `SMT_CNT_RST;
              irq_d = 1'b1;
            end
          end
          else if (trig_mode)
          begin
            if (tick && match)
            begin
              cnt_d = `SMT_CNT_RST;
              irq_d = 1'b1;
              state_d = ST_HALT;
            end
            else if (opp_edge && ctrl_q.trigger_stop_sel)
            begin
              cnt_d = `SMT_CNT_RST;
              state_d = ST_HALT;
            end
            else if (tick)
              cnt_d = count_out + 16'h1;
          end
          else if (cnt_tick)
          begin
            if (match)
            begin
              cnt_d = `SMT_CNT_RST;
              irq_d = 1'b1;
            end
            else
              cnt_d = count_out + 16'h1;
          end
        end
        ST_HALT:
        begin
          cnt_d = `SMT_CNT_RST;
          if (trig_edge)
            state_d = ST_RUN;
        end
        default:
        begin
          state_d = ST_IDLE;
          cnt_d = `SMT_CNT_RST;
        end
      endcase
  end

  always_ff @(posedge clock_in)
  begin
    if (srst_in)
    begin
      state_q <= ST_IDLE;
      count_out <= `SMT_CNT_RST;
      running_out <= 1'b0;
      timer_match_irq_out <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      count_out <= cnt_d;
      running_out <= (state_d == ST_RUN);
      timer_match_irq_out <= irq_d;
    end
  end

  // ---------------------------------------------------------------
  // timer registers, two-byte staging
  // ---------------------------------------------------------------
  always_ff @(posedge clock_in)
  begin
    if (srst_in)
      lo_q <= '0;
    else if (reg_wr_in.wr_lo)
      lo_q <= reg_wr_in.data;
  end

  // upper byte write arms, next source clock applies; arm wins
  for (genvar i = 0; i < 2; i++)
  begin : g_stage
    always_ff @(posedge clock_in)
    begin
      if (srst_in)
      begin
        stage_q[i] <= '0;
        pend_q[i] <= 1'b0;
      end
      else if (reg_wr_in.wr_hi && (reg_wr_in.sel_capture == 1'(i)))
      begin
        stage_q[i] <= {reg_wr_in.data, lo_q};
        pend_q[i] <= 1'b1;
      end
      else if (src_clk)
        pend_q[i] <= 1'b0;
    end
  end

  always_ff @(posedge clock_in)
  begin
    if (srst_in)
      compare_period_reg_out <= `SMT_CMP_RST;
    else if (src_clk && pend_q[0])
      compare_period_reg_out <= stage_q[0];
  end

  always_ff @(posedge clock_in)
  begin
    if (srst_in)
      capture_second_reg_out <= `SMT_CAP_RST;
    else if (src_clk && ctrl_q.auto_capture_en && state_q == ST_RUN
             && !trig_mode)
      capture_second_reg_out <= count_out;
    else if (src_clk && pend_q[1])
      capture_second_reg_out <= stage_q[1];
  end

  assign timer_control_reg_out = ctrl_q;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clock_in);
  endclocking
  default disable iff (srst_in);
  sequence s_trig_armed;
    state_q == ST_HALT && trig_mode && trig_edge && ctrl_hold;
  endsequence
  sequence s_trig_fire;
    state_q == ST_RUN && trig_mode && tick && match && ctrl_hold;
  endsequence
  sequence s_trig_cleared;
    state_q == ST_HALT && count_out == 16'h0;
  endsequence
  reset_clear_a:
    assert property (@(posedge clock_in) disable iff (1'b0)
      srst_in |=> count_out == 16'h0 && state_q == ST_IDLE
                  && !timer_match_irq_out)
    else $error("counter not cleared by reset");
  timer_wrap_a:
    assert property (state_q == ST_RUN && timer_mode && tick && match
                     && ctrl_hold
                     |=> count_out == 16'h0 && timer_match_irq_out
                     ##1 !timer_match_irq_out)
    else $error("timer match did not wrap with one pulse");
  timer_step_a:
    assert property (state_q == ST_RUN && timer_mode && tick && !match
                     && ctrl_hold
                     |=> count_out == $past(count_out) + 16'h1
                     && !timer_match_irq_out)
    else $error("timer did not step by one");
  capture_copy_a:
    assert property (state_q == ST_RUN && (timer_mode || event_mode)
                     && ctrl_q.auto_capture_en && src_clk
                     |=> capture_second_reg_out == $past(count_out))
    else $error("capture register missed running count");
  trig_start_a:
    assert property (s_trig_armed |=> state_q == ST_RUN
                     && count_out == 16'h0 ##1 running_out)
    else $error("trigger edge did not start counter");
  trig_match_a:
    assert property (s_trig_fire |=> s_trig_cleared
                     ##0 timer_match_irq_out)
    else $error("trigger match did not halt with interrupt");
  opp_stop_a:
    assert property (state_q == ST_RUN && trig_mode
                     && ctrl_q.trigger_stop_sel && opp_edge
                     && !(tick && match) && ctrl_hold
                     |=> s_trig_cleared ##0 !timer_match_irq_out)
    else $error("opposite edge did not halt silently");
  opp_ignore_a:
    assert property (state_q == ST_RUN && trig_mode
                     && !ctrl_q.trigger_stop_sel
                     && !(tick && match) && ctrl_hold
                     |=> state_q == ST_RUN)
    else $error("edge wrongly stopped trigger counter");
  event_match_a:
    assert property (state_q == ST_RUN && event_mode && opp_edge
                     && match && ctrl_hold
                     |=> timer_match_irq_out && count_out == 16'h0)
    else $error("event match not taken at opposite edge");
  window_hold_a:
    assert property (state_q == ST_RUN && win_mode && !win_active
                     && ctrl_hold
                     |=> $stable(count_out))
    else $error("window counted outside window");
  stop_entry_a:
    assert property (stop_entry_in |=> ctrl_q.start_ctrl == 2'b00
                     ##1 !running_out && count_out == 16'h0)
    else $error("stop entry did not halt timer");
  reg_apply_a:
    assert property (pend_q[0] && src_clk && !reg_wr_in.wr_hi
                     |=> compare_period_reg_out == $past(stage_q[0])
                     && !pend_q[0])
    else $error("staged compare value not applied");

endmodule // smt_timer

// file: smt_cfg.svh
//
// Operation
// - timer mode counts, matches, interrupts, wraps to zero
// - auto-capture copies count each source clock, except in trigger mode
// - taps 2^11, 2^7, 2^3; slow: 00 only
// - trigger edge on pin starts counting
// - trigger mode match clears, halts, interrupts
// - stop-select: opposite edge halts, no interrupt
// - halted trigger counter restarts on trigger edge
// - no stop-select: ignore opposite and repeat edges
// - pin filter rejects 4/fc, passes 12/fc; slow mode passes every change
// - event mode counts selected pin edges
// - event match at opposite edge, interrupt, clear
// - auto-capture also works in event mode
// - window mode counts ticks while window active
// - window mode match interrupts and clears
// - six modes; first four built here
// - mode 00 standard, 01 window, others unsupported
// - start 00 stops/clears, 01 command start
// - register value applies at next source clock
// - stop mode entry forces start to 00
`ifndef SMT_CFG_SVH
`define SMT_CFG_SVH

// ---------------------------------------------------------------
// field codes
// ---------------------------------------------------------------
`define SMT_START_STOP 2'b00
`define SMT_START_CMD 2'b01
`define SMT_MODE_STD 2'b00
`define SMT_MODE_WIN 2'b01
`define SMT_SRC_EXT 2'b11
`define SMT_SRC_SLOW_OK 2'b00

// ---------------------------------------------------------------
// reset values
// ---------------------------------------------------------------
`define SMT_CNT_RST 16'h0000
`define SMT_CMP_RST 16'hffff
`define SMT_CAP_RST 16'h0000

// ---------------------------------------------------------------
// divider taps and rates
// ---------------------------------------------------------------
`define SMT_TAP_LOW 11
`define SMT_TAP_MID 7
`define SMT_TAP_HIGH 3
`define SMT_TAP_FS 3
`define SMT_CLK_HZ 100000000
`define SMT_FS_HZ 32768
`define SMT_FS_DIV (`SMT_CLK_HZ / `SMT_FS_HZ)

// ---------------------------------------------------------------
// pin filter, in fc periods
// ---------------------------------------------------------------
`define SMT_FILT_REJ_FC 4
`define SMT_FILT_DET_FC 12
`define SMT_FILT_CYC ((`SMT_FILT_REJ_FC + `SMT_FILT_DET_FC) / 2)

`endif

// file: smt_pkg.sv
package smt_pkg;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RUN = 2'b01,
    ST_HALT = 2'b10
  } smt_state_e;

  typedef struct packed {
    logic auto_capture_en;
    logic trigger_stop_sel;
    logic [1:0] start_ctrl;
    logic [1:0] source_clk_sel;
    logic [1:0] op_mode_sel;
  } smt_ctrl_s;

  typedef struct packed {
    logic wr_lo;
    logic wr_hi;
    logic sel_capture;
    logic [7:0] data;
  } smt_wr_s;

endpackage

// file: smt_prescaler.sv
`timescale 1ns/1ps
`include "smt_cfg.svh"

module smt_prescaler #(
  parameter int FS_DIV = `SMT_FS_DIV
) (
  // clock and reset
  input wire logic clock_in,
  input wire logic srst_in,
  // selection
  input wire logic [1:0] source_clk_sel_in,
  input wire logic divider_tap_sel_in,
  input wire logic slow_mode_in,
  // selected source clock enable
  output logic tick_out
);

  logic [10:0] fc_div_q;
  logic [11:0] fs_div_q;
  logic [2:0] fs_pre_q;
  logic fs_tick;
  logic fs8_tick;
  logic tick_d;

  assign fs_tick = (fs_div_q == 12'(FS_DIV - 1));
  assign fs8_tick = fs_tick && (&fs_pre_q);

  always_ff @(posedge clock_in)
  begin
    if (srst_in)
    begin
      fc_div_q <= '0;
      fs_div_q <= '0;
      fs_pre_q <= '0;
    end
    else
    begin
      fc_div_q <= fc_div_q + 11'h1;
      fs_div_q <= fs_tick ? 12'h0 : fs_div_q + 12'h1;
      if (fs_tick)
        fs_pre_q <= fs_pre_q + 3'h1;
    end
  end

  // ---------------------------------------------------------------
  // tap select
  // ---------------------------------------------------------------
  always_comb
  begin
    tick_d = 1'b0;
    if (slow_mode_in)
      tick_d = (source_clk_sel_in == `SMT_SRC_SLOW_OK) && fs8_tick;
    else
      unique case (source_clk_sel_in)
        2'b00: tick_d = divider_tap_sel_in ? fs8_tick
                        : &fc_div_q[`SMT_TAP_LOW-1:0];
        2'b01: tick_d = &fc_div_q[`SMT_TAP_MID-1:0];
        2'b10: tick_d = &fc_div_q[`SMT_TAP_HIGH-1:0];
        2'b11: tick_d = 1'b0;
      endcase
  end

  always_ff @(posedge clock_in)
  begin
    if (srst_in)
      tick_out <= 1'b0;
    else
      tick_out <= tick_d;
  end

endmodule // smt_prescaler

// file: smt_pin_filter.sv
`timescale 1ns/1ps
`include "smt_cfg.svh"

module smt_pin_filter #(
  parameter int FILT_CYC = `SMT_FILT_CYC
) (
  // clock and reset
  input wire logic clock_in,
  input wire logic srst_in,
  // pin and mode
  input wire logic timer_input_pin_in,
  input wire logic slow_mode_in,
  // filtered level and edges
  output logic level_out,
  output logic rise_out,
  output logic fall_out
);

  logic sync1_q;
  logic sync2_q;
  logic [3:0] stable_q;
  logic take;

  assign take = slow_mode_in
                || (stable_q == 4'(FILT_CYC - 1));

  always_ff @(posedge clock_in)
  begin
    if (srst_in)
    begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
    end
    else
    begin
      sync1_q <= timer_input_pin_in;
      sync2_q <= sync1_q;
    end
  end

  // outside slow mode, level must differ for FILT_CYC cycles before it is taken
  always_ff @(posedge clock_in)
  begin
    if (srst_in)
    begin
      stable_q <= '0;
      level_out <= 1'b0;
      rise_out <= 1'b0;
      fall_out <= 1'b0;
    end
    else
    begin
      rise_out <= 1'b0;
      fall_out <= 1'b0;
      if (sync2_q == level_out)
        stable_q <= '0;
      else if (take)
      begin
        stable_q <= '0;
        level_out <= sync2_q;
        rise_out <= sync2_q;
        fall_out <= ~sync2_q;
      end
      else
        stable_q <= stable_q + 4'h1;
    end
  end

endmodule // smt_pin_filter

// file: smt_pulse_src.sv
`timescale 1ns/1ps

module smt_pulse_src (
  // clock
  input wire logic clock_in,
  // timer input pin
  output logic pin_out
);
  initial pin_out = 1'b0;

  // holds a level for a number of cycles, driven off the sampling edge
  // counted levels are held at least eight cycles
  task automatic drive(input logic lvl, input int cycles);
    @(negedge clock_in);
    pin_out = lvl;
    repeat (cycles - 1) @(negedge clock_in);
  endtask
endmodule // smt_pulse_src

// file: tb_top.sv
`timescale 1ns/1ps

module tb_top;
  import smt_pkg::*;
  logic clock_in = 1'b0;
  logic srst_in = 1'b1;
  logic ctrl_wr = 1'b0;
  smt_ctrl_s ctrl = '0;
  logic stop_entry = 1'b0;
  logic slow = 1'b0;
  logic tap_sel = 1'b0;
  smt_wr_s reg_wr = '0;
  logic pin;
  logic [15:0] count;
  logic [15:0] cmp;
  logic [15:0] cap;
  logic [15:0] snap;
  smt_ctrl_s ctrl_rb;
  logic running;
  logic irq;
  int fail_count = 0;
  int compares = 0;
  int irqs = 0;
  int base;
  int n;

  always #5 clock_in = ~clock_in;

  // counts each pulse as it rises, so it is seen at the next falling edge
  always @(posedge irq)
    irqs++;

  smt_pulse_src u_smt_pulse_src (.clock_in(clock_in), .pin_out(pin));

  smt_timer #(.FS_DIV(4), .FILT_CYC(8)) u_smt_timer (
    .clock_in(clock_in),
    .srst_in(srst_in),
    .ctrl_wr_in(ctrl_wr),
    .ctrl_in(ctrl),
    .divider_tap_sel_in(tap_sel),
    .slow_mode_in(slow),
    .stop_entry_in(stop_entry),
    .reg_wr_in(reg_wr),
    .timer_input_pin_in(pin),
    .count_out(count),
    .compare_period_reg_out(cmp),
    .capture_second_reg_out(cap),
    .timer_control_reg_out(ctrl_rb),
    .running_out(running),
    .timer_match_irq_out(irq)
  );

  // ---------------------------------------------------------------
  // access and compare tasks
  // ---------------------------------------------------------------
  task automatic chk16(input logic [15:0] got, input logic [15:0] exp,
                       input string what);
    compares++;
    if (got !== exp)
    begin
      fail_count++;
      $display("mismatch at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask

  task automatic chk1(input logic got, input logic exp, input string what);
    compares++;
    if (got !== exp)
    begin
      fail_count++;
      $display("mismatch at %0t: %s got %b want %b", $time, what, got, exp);
    end
  endtask

  // fields: capture, stop select, start, source, mode
  task automatic set_ctrl(input logic [7:0] v);
    @(negedge clock_in);
    ctrl_wr = 1'b1;
    ctrl = smt_ctrl_s'(v);
    @(negedge clock_in);
    ctrl_wr = 1'b0;
    repeat (3) @(negedge clock_in);
  endtask

  task automatic wr_reg(input logic sel, input logic [15:0] v,
                        input logic hi_too);
    @(negedge clock_in);
    reg_wr = smt_wr_s'({1'b1, 1'b0, sel, v[7:0]});
    @(negedge clock_in);
    reg_wr = smt_wr_s'({1'b0, hi_too, sel, v[15:8]});
    @(negedge clock_in);
    reg_wr = '0;
  endtask

  task automatic wait_irq(input int max);
    n = 0;
    while (irq !== 1'b1 && n < max)
    begin
      @(negedge clock_in);
      n++;
    end
  endtask

  task automatic give_verdict();
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  initial
  begin
    repeat (20000) @(posedge clock_in);
    fail_count++;
    $display("mismatch at %0t: watchdog expired", $time);
    give_verdict();
  end

  // ---------------------------------------------------------------
  // tests
  // ---------------------------------------------------------------
  initial
  begin
    repeat (12) @(negedge clock_in);
    chk16(count, 16'h0000, "reset count");
    chk16(cmp, 16'hffff, "reset compare");
    chk16(cap, 16'h0000, "reset capture");
    chk1(running, 1'b0, "reset running");
    srst_in = 1'b0;
    // timer mode, fc/8 ticks, period of four ticks
    set_ctrl(8'h08);
    wr_reg(1'b0, 16'h0003, 1'b1);
    set_ctrl(8'h98);
    wait_irq(100);
    chk1(irq, 1'b1, "timer irq");
    chk16(count, 16'h0000, "cleared at match");
    chk16(cmp, 16'h0003, "compare applied");
    @(negedge clock_in);
    wait_irq(100);
    chk16(16'(n), 16'd31, "irq period");
    n = 0;
    while (cap !== 16'h0003 && n < 64)
    begin
      @(negedge clock_in);
      n++;
    end
    chk16(cap, 16'h0003, "captured count");
    wr_reg(1'b0, 16'h0055, 1'b0);
    repeat (20) @(negedge clock_in);
    chk16(cmp, 16'h0003, "low byte only");
    // stop mode entry
    @(negedge clock_in);
    stop_entry = 1'b1;
    @(negedge clock_in);
    stop_entry = 1'b0;
    repeat (3) @(negedge clock_in);
    chk16({14'h0, ctrl_rb.start_ctrl}, 16'h0000, "start forced");
    chk16({8'h00, ctrl_rb}, 16'h0088, "other fields kept");
    chk1(running, 1'b0, "stopped");
    chk16(count, 16'h0000, "stop clears");
    // event mode, rising edges
    set_ctrl(8'h0c);
    set_ctrl(8'h2c);
    repeat (2)
    begin
      u_smt_pulse_src.drive(1'b1, 12);
      u_smt_pulse_src.drive(1'b0, 12);
    end
    chk16(count, 16'h0002, "edge count");
    u_smt_pulse_src.drive(1'b1, 3);
    u_smt_pulse_src.drive(1'b0, 12);
    chk16(count, 16'h0002, "short pulse");
    base = irqs;
    u_smt_pulse_src.drive(1'b1, 12);
    chk16(16'(irqs - base), 16'd0, "no irq on count edge");
    u_smt_pulse_src.drive(1'b0, 12);
    chk16(16'(irqs - base), 16'd1, "irq on opposite edge");
    chk16(count, 16'h0000, "event clear");
    // longer compare, applied by a brief timer run
    set_ctrl(8'h08);
    wr_reg(1'b0, 16'h0010, 1'b1);
    set_ctrl(8'h18);
    wr_reg(1'b1, 16'h1234, 1'b1);
    repeat (20) @(negedge clock_in);
    chk16(cmp, 16'h0010, "compare 16");
    chk16(cap, 16'h1234, "capture reg write");
    set_ctrl(8'h08);
    chk1(running, 1'b0, "stop code");
    // trigger with stop select
    set_ctrl(8'h48);
    set_ctrl(8'h68);
    chk1(running, 1'b0, "waits for trigger");
    base = irqs;
    u_smt_pulse_src.drive(1'b1, 30);
    chk1(running, 1'b1, "trigger start");
    u_smt_pulse_src.drive(1'b0, 30);
    chk1(running, 1'b0, "opposite halts");
    chk16(count, 16'h0000, "opposite clears");
    chk16(16'(irqs - base), 16'd0, "no irq on abort");
    u_smt_pulse_src.drive(1'b1, 30);
    chk1(running, 1'b1, "restart");
    wait_irq(200);
    chk1(irq, 1'b1, "trigger match");
    repeat (2) @(negedge clock_in);
    chk1(running, 1'b0, "halt at match");
    chk16(count, 16'h0000, "clear at match");
    u_smt_pulse_src.drive(1'b0, 20);
    // trigger without stop select; later edges ignored
    set_ctrl(8'h08);
    set_ctrl(8'h28);
    u_smt_pulse_src.drive(1'b1, 20);
    u_smt_pulse_src.drive(1'b0, 20);
    chk1(running, 1'b1, "opposite ignored");
    u_smt_pulse_src.drive(1'b1, 20);
    wait_irq(200);
    chk1(irq, 1'b1, "match irq");
    chk1(n < 105, 1'b1, "retrigger ignored");
    u_smt_pulse_src.drive(1'b0, 20);
    // window mode, positive logic, slow window pulses
    set_ctrl(8'h09);
    set_ctrl(8'h29);
    repeat (50) @(negedge clock_in);
    chk16(count, 16'h0000, "window closed");
    base = irqs;
    u_smt_pulse_src.drive(1'b1, 60);
    chk1(count != 16'h0 && count < 16'h10, 1'b1, "window counts");
    // the filter delays the close, so snapshot once it has settled
    u_smt_pulse_src.drive(1'b0, 15);
    snap = count;
    u_smt_pulse_src.drive(1'b0, 25);
    chk16(count, snap, "window holds");
    u_smt_pulse_src.drive(1'b1, 150);
    chk16(16'(irqs - base), 16'd1, "window match");
    // slow mode: code 10 gives no ticks, code 00 ticks at fs/8
    set_ctrl(8'h08);
    slow = 1'b1;
    set_ctrl(8'h18);
    repeat (100) @(negedge clock_in);
    chk16(count, 16'h0000, "slow code 10 idle");
    set_ctrl(8'h10);
    wait_irq(600);
    chk1(irq, 1'b1, "slow irq");
    @(negedge clock_in);
    wait_irq(600);
    chk16(16'(n), 16'd543, "slow irq period");
    // normal mode with the slow divider tap on code 00
    slow = 1'b0;
    tap_sel = 1'b1;
    wait_irq(600);
    @(negedge clock_in);
    wait_irq(600);
    chk16(16'(n), 16'd543, "fs tap period");
    give_verdict();
  end
endmodule // tb_top
